// *** add_logic_bit_alu.sv ***
// Functional notes
// - Add-with-carry stores dst plus src plus carry
// - Carry flag set on carry out bit 7
// - Overflow on same-sign operands, opposite-sign result
// - Zero and sign follow 8-bit add result
// - Both adds clear the decimal-adjust flag
// - Add-with-carry half-carry from bit 3
// - Plain add stores dst plus src, same flags
// - Plain add half-carry from low nibble
// - Add-with-carry opcodes 12 to 16 decode
// - Byte conjunction stores dst AND src
// - Conjunction flags: Z, S=bit7, V=0, rest kept
// - Conjunction opcodes 52 to 56 decode
// - Bit conjunction changes one destination bit only
// - Bit conjunction: C kept, Z from bit, S=0
// - Opcode 67, second byte fields, selector bit
`timescale 1ns/100ps
`default_nettype none
module add_logic_bit_alu (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Instruction issue: opcode, second byte and fetched operands
  input  wire logic       start,
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] byte2,
  input  wire logic [7:0] dst_in,
  input  wire logic [7:0] src_in,
  // Instruction status
  output logic            busy,
  output logic            done,
  output logic            illegal,
  output logic [1:0]      instr_len,
  output logic [3:0]      instr_cycles,
  // Committed result and flags
  output logic [7:0]      result,
  output logic [3:0]      dst_waddr,
  output logic [5:0]      flags
);

  // Decode outputs
  alu_pkg::op_class_t cls;
  logic [1:0] dec_len;      // Instruction length in bytes
  logic [3:0] dec_cyc;      // Execution cycles

  // Opcode decode to class, length and cycle count
  always_comb begin
    cls     = alu_pkg::OPC_NONE;
    dec_len = alu_pkg::LEN_LONG;
    dec_cyc = alu_pkg::CYC_LONG;
    case (opcode)
      alu_pkg::OP_ADC_RR: begin
        cls     = alu_pkg::OPC_ADC;
        dec_len = alu_pkg::LEN_SHORT;
        dec_cyc = alu_pkg::CYC_SHORT;
      end
      alu_pkg::OP_ADC_RIR: begin
        cls     = alu_pkg::OPC_ADC;
        dec_len = alu_pkg::LEN_SHORT;
      end
      alu_pkg::OP_ADC_GG, alu_pkg::OP_ADC_GIG, alu_pkg::OP_ADC_IM: begin
        cls = alu_pkg::OPC_ADC;
      end
      alu_pkg::OP_ADD_RR: begin
        cls     = alu_pkg::OPC_ADD;
        dec_len = alu_pkg::LEN_SHORT;
        dec_cyc = alu_pkg::CYC_SHORT;
      end
      alu_pkg::OP_ADD_RIR: begin
        cls     = alu_pkg::OPC_ADD;
        dec_len = alu_pkg::LEN_SHORT;
      end
      alu_pkg::OP_ADD_GG, alu_pkg::OP_ADD_GIG, alu_pkg::OP_ADD_IM: begin
        cls = alu_pkg::OPC_ADD;
      end
      alu_pkg::OP_AND_RR: begin
        cls     = alu_pkg::OPC_AND;
        dec_len = alu_pkg::LEN_SHORT;
        dec_cyc = alu_pkg::CYC_SHORT;
      end
      alu_pkg::OP_AND_RIR: begin
        cls     = alu_pkg::OPC_AND;
        dec_len = alu_pkg::LEN_SHORT;
      end
      alu_pkg::OP_AND_GG, alu_pkg::OP_AND_GIG, alu_pkg::OP_AND_IM: begin
        cls = alu_pkg::OPC_AND;
      end
      alu_pkg::OP_BITAND: begin
        cls = alu_pkg::OPC_BAND;
      end
      default: begin
        cls = alu_pkg::OPC_NONE;
      end
    endcase
  end

  // Arithmetic core results
  logic [8:0] sum9;         // Full sum with carry out
  logic [4:0] low5;         // Low nibble sum with half carry
  logic       cin;          // Carry into the add
  logic [7:0] and_res;      // Byte conjunction
  logic [2:0] bidx;         // Bit index field
  logic       bsel;         // Bit-form selector
  logic [7:0] band_res;     // Bit conjunction result
  logic       band_bit;     // The bit that was written

  // Datapath: adder, byte and bit conjunction
  always_comb begin
    cin      = (cls == alu_pkg::OPC_ADC) ? flags[alu_pkg::FLAG_C] : 1'b0;
    // plain add has no carry in
    sum9     = {1'b0, dst_in} + {1'b0, src_in} + {8'h00, cin};
    // nibble carry out of bit 3
    low5     = {1'b0, dst_in[3:0]} + {1'b0, src_in[3:0]} + {4'h0, cin};
    and_res  = dst_in & src_in;
    bidx     = byte2[alu_pkg::BIDX_HI:alu_pkg::BIDX_LO];
    bsel     = byte2[alu_pkg::SEL_POS];
    band_res = dst_in;
    if (bsel) begin
      band_bit       = dst_in[bidx] & src_in[0];
      band_res[bidx] = band_bit;
    end else begin
      band_bit       = dst_in[0] & src_in[bidx];
      band_res[0]    = band_bit;
    end
  end

  // Committed state
  logic [7:0] result_reg, result_next;
  logic [5:0] flags_reg, flags_next;
  logic [3:0] waddr_reg, waddr_next;
  logic [3:0] cnt_reg, cnt_next;      // Cycles left in the instruction
  logic [1:0] len_reg, len_next;
  logic [3:0] cyc_reg, cyc_next;
  logic       done_reg, done_next;
  logic       ill_reg, ill_next;
  logic [7:0] pend_res_reg, pend_res_next;   // Held until completion
  logic [5:0] pend_flg_reg, pend_flg_next;
  logic       busy_w;

  assign busy_w = (cnt_reg != 4'h0);

  // Next-state: capture at issue, commit both at completion
  always_comb begin
    result_next   = result_reg;
    flags_next    = flags_reg;
    waddr_next    = waddr_reg;
    cnt_next      = cnt_reg;
    len_next      = len_reg;
    cyc_next      = cyc_reg;
    done_next     = 1'b0;
    ill_next      = 1'b0;
    pend_res_next = pend_res_reg;
    pend_flg_next = pend_flg_reg;
    if (start && !busy_w) begin
      // Unknown opcodes are flagged and leave state alone
      if (cls == alu_pkg::OPC_NONE) begin
        ill_next = 1'b1;
      end else begin
        len_next      = dec_len;
        cyc_next      = dec_cyc;
        cnt_next      = dec_cyc - 4'h1;
        waddr_next    = byte2[alu_pkg::WADDR_HI:alu_pkg::WADDR_LO];
        pend_flg_next = flags_reg;
        case (cls)
          alu_pkg::OPC_ADC, alu_pkg::OPC_ADD: begin
            pend_res_next = sum9[7:0];
            pend_flg_next[alu_pkg::FLAG_C] = sum9[8];
            pend_flg_next[alu_pkg::FLAG_Z] = (sum9[7:0] == 8'h00);
            pend_flg_next[alu_pkg::FLAG_S] = sum9[7];
            pend_flg_next[alu_pkg::FLAG_V] = (dst_in[7] == src_in[7]) &&
                                             (sum9[7] != dst_in[7]);
            pend_flg_next[alu_pkg::FLAG_D] = 1'b0;
            pend_flg_next[alu_pkg::FLAG_H] = low5[4];
          end
          alu_pkg::OPC_AND: begin
            pend_res_next = and_res;
            pend_flg_next[alu_pkg::FLAG_Z] = (and_res == 8'h00);
            pend_flg_next[alu_pkg::FLAG_S] = and_res[7];
            pend_flg_next[alu_pkg::FLAG_V] = 1'b0;
          end
          alu_pkg::OPC_BAND: begin
            pend_res_next = band_res;
            // carry kept, V D H left as they were
            pend_flg_next[alu_pkg::FLAG_Z] = ~band_bit;
            pend_flg_next[alu_pkg::FLAG_S] = 1'b0;
          end
          default: begin
            pend_res_next = pend_res_reg;
          end
        endcase
      end
    end else if (busy_w) begin
      cnt_next = cnt_reg - 4'h1;
      // commit result and flags on the same edge
      if (cnt_reg == 4'h1) begin
        result_next = pend_res_reg;
        flags_next  = pend_flg_reg;
        done_next   = 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (srst) begin
      result_reg   <= 8'h00;
      flags_reg    <= alu_pkg::FLAGS_RESET;
      waddr_reg    <= 4'h0;
      cnt_reg      <= 4'h0;
      len_reg      <= 2'h0;
      cyc_reg      <= 4'h0;
      done_reg     <= 1'b0;
      ill_reg      <= 1'b0;
      pend_res_reg <= 8'h00;
      pend_flg_reg <= alu_pkg::FLAGS_RESET;
    end else begin
      result_reg   <= result_next;
      flags_reg    <= flags_next;
      waddr_reg    <= waddr_next;
      cnt_reg      <= cnt_next;
      len_reg      <= len_next;
      cyc_reg      <= cyc_next;
      done_reg     <= done_next;
      ill_reg      <= ill_next;
      pend_res_reg <= pend_res_next;
      pend_flg_reg <= pend_flg_next;
    end
  end

  assign busy         = busy_w;
  assign done         = done_reg;
  assign illegal      = ill_reg;
  assign instr_len    = len_reg;
  assign instr_cycles = cyc_reg;
  assign result       = result_reg;
  assign dst_waddr    = waddr_reg;
  assign flags        = flags_reg;

  // Checks
  sequence issue_s;
    start && !busy && (cls != alu_pkg::OPC_NONE);
  endsequence
  chk_done_spacing: assert property (@(posedge clk) disable iff (srst)
    issue_s |-> ##(1) (busy ##[2:5] done))
    else $error("done not within instruction cycles");
  chk_short_cycles: assert property (@(posedge clk) disable iff (srst)
    (start && !busy && opcode == alu_pkg::OP_ADD_RR) |-> ##4 done)
    else $error("short add not four cycles");
  chk_long_cycles: assert property (@(posedge clk) disable iff (srst)
    (start && !busy && opcode == alu_pkg::OP_AND_GG) |-> ##1 !done[*5] ##1 done)
    else $error("long and not six cycles");
  chk_add_result: assert property (@(posedge clk) disable iff (srst)
    (start && !busy && opcode == alu_pkg::OP_ADD_RR) |->
      ##4 (result == 8'(($past(dst_in, 4) + $past(src_in, 4)))))
    else $error("add result wrong");
  chk_add_dflag: assert property (@(posedge clk) disable iff (srst)
    (start && !busy && (cls == alu_pkg::OPC_ADC || cls == alu_pkg::OPC_ADD))
      |-> ##[4:6] (done && !flags[alu_pkg::FLAG_D]))
    else $error("decimal adjust not cleared");
  chk_and_carry: assert property (@(posedge clk) disable iff (srst)
    (start && !busy && cls == alu_pkg::OPC_AND) |->
      ##6 (flags[alu_pkg::FLAG_C] == $past(flags[alu_pkg::FLAG_C], 6) &&
           !flags[alu_pkg::FLAG_V]))
    else $error("and touched carry or kept overflow");
  chk_band_sign: assert property (@(posedge clk) disable iff (srst)
    (start && !busy && cls == alu_pkg::OPC_BAND) |->
      ##6 (!flags[alu_pkg::FLAG_S] && done))
    else $error("bit and sign not cleared");
  chk_commit_together: assert property (@(posedge clk) disable iff (srst)
    (!done && !$past(done)) |-> ($stable(result) && $stable(flags)))
    else $error("state changed outside completion");
endmodule
`default_nettype wire

// *** alu_pkg.sv ***
`default_nettype none
package alu_pkg;
  // Opcodes for the add-with-carry group
  localparam logic [7:0] OP_ADC_RR  = 8'h12;
  localparam logic [7:0] OP_ADC_RIR = 8'h13;
  localparam logic [7:0] OP_ADC_GG  = 8'h14;
  localparam logic [7:0] OP_ADC_GIG = 8'h15;
  localparam logic [7:0] OP_ADC_IM  = 8'h16;
  // Opcodes for the plain add group
  localparam logic [7:0] OP_ADD_RR  = 8'h02;
  localparam logic [7:0] OP_ADD_RIR = 8'h03;
  localparam logic [7:0] OP_ADD_GG  = 8'h04;
  localparam logic [7:0] OP_ADD_GIG = 8'h05;
  localparam logic [7:0] OP_ADD_IM  = 8'h06;
  // Opcodes for the byte conjunction group
  localparam logic [7:0] OP_AND_RR  = 8'h52;
  localparam logic [7:0] OP_AND_RIR = 8'h53;
  localparam logic [7:0] OP_AND_GG  = 8'h54;
  localparam logic [7:0] OP_AND_GIG = 8'h55;
  localparam logic [7:0] OP_AND_IM  = 8'h56;
  // Single-bit conjunction
  localparam logic [7:0] OP_BITAND  = 8'h67;
  // Field layout of the bit-operation second byte
  localparam int SEL_POS     = 0;
  localparam int BIDX_LO     = 1;
  localparam int BIDX_HI     = 3;
  localparam int WADDR_LO    = 4;
  localparam int WADDR_HI    = 7;
  // Flag positions in the flag vector
  localparam int FLAG_C      = 5;
  localparam int FLAG_Z      = 4;
  localparam int FLAG_S      = 3;
  localparam int FLAG_V      = 2;
  localparam int FLAG_D      = 1;
  localparam int FLAG_H      = 0;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  // Instruction lengths and cycle counts
  localparam logic [1:0] LEN_SHORT   = 2'h2;
  localparam logic [1:0] LEN_LONG    = 2'h3;
  localparam logic [3:0] CYC_SHORT   = 4'h4;
  localparam logic [3:0] CYC_LONG    = 4'h6;
  // Operation classes
  typedef enum {OPC_NONE, OPC_ADC, OPC_ADD, OPC_AND, OPC_BAND} op_class_t;
endpackage
`default_nettype wire

// *** test_add_logic_bit_alu.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_add_logic_bit_alu;
  // Stimulus, all driven 1 ns after the rising edge
  logic       clk    = 1'b0;
  logic       srst   = 1'b1;
  logic       start  = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] byte2  = 8'h00;
  logic [7:0] dst_in = 8'h00;
  logic [7:0] src_in = 8'h00;
  // Observed outputs
  logic       busy;
  logic       done;
  logic       illegal;
  logic [1:0] instr_len;
  logic [3:0] instr_cycles;
  logic [7:0] result;
  logic [3:0] dst_waddr;
  logic [5:0] flags;
  // Bookkeeping; fl mirrors the committed flags as the bench expects them
  int         n_errors = 0;
  int         checked  = 0;
  int         cycles   = 0;
  logic [5:0] fl       = 6'h00;

  // 250 MHz clock
  always #2 clk = ~clk;

  add_logic_bit_alu uut (
    .clk(clk), .srst(srst), .start(start), .opcode(opcode), .byte2(byte2),
    .dst_in(dst_in), .src_in(src_in), .busy(busy), .done(done), .illegal(illegal),
    .instr_len(instr_len), .instr_cycles(instr_cycles), .result(result),
    .dst_waddr(dst_waddr), .flags(flags)
  );

  // Single comparison point; case inequality so unknowns never match
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // Expected sum as {result, C Z S V D H}; half-carry includes carry-in
  function automatic logic [13:0] add_exp(input logic [7:0] d, s, input logic cin);
    logic [8:0] sum;
    logic       h;
    logic       v;
    sum = {1'b0, d} + {1'b0, s} + {8'h00, cin};
    h = ({1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cin}) > 5'h0F;
    v = (d[7] == s[7]) && (sum[7] != d[7]);
    return {sum[7:0], sum[8], sum[7:0] == 8'h00, sum[7], v, 1'b0, h};
  endfunction

  // Present one instruction for exactly one taking edge
  task automatic issue(input logic [7:0] op, b2, d, s);
    opcode = op;
    byte2  = b2;
    dst_in = d;
    src_in = s;
    start  = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
  endtask

  // Count edges from the taking edge to the commit pulse, then judge
  task automatic wait_done(input int first, n, input logic [7:0] er,
                           input logic [5:0] ef, mask);
    int k;
    k = first;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 20);
    chk("done latency", k[7:0], n[7:0]);
    chk("result", result, er);
    chk("flags", {2'b00, flags & mask}, {2'b00, ef & mask});
    fl = (fl & ~mask) | (ef & mask);
  endtask

  // Full instruction: issue, status right after taking, commit
  task automatic run(input logic [7:0] op, b2, d, s, input int n,
                     input logic [7:0] er, input logic [5:0] ef, mask);
    issue(op, b2, d, s);
    chk("busy", {7'h00, busy}, 8'h01);
    // Low-nibble 2 and 3 forms are two bytes long, all others three
    chk("length", {6'h00, instr_len}, (op[3:0] < 4'h4) ? 8'h02 : 8'h03);
    chk("cycles", {4'h0, instr_cycles}, n[7:0]);
    // One edge, the taking edge, has already gone by inside issue
    wait_done(1, n, er, ef, mask);
  endtask

  // Plain add, all five forms back to back: carry, zero, overflow, half-carry
  task automatic test_add();
    logic [7:0]  da [5];
    logic [7:0]  sa [5];
    logic [13:0] e;
    da = '{8'hFF, 8'h7F, 8'h80, 8'h12, 8'h08};
    sa = '{8'h01, 8'h01, 8'h80, 8'h03, 8'h08};
    for (int i = 0; i < 5; i++) begin
      e = add_exp(da[i], sa[i], 1'b0);
      run(alu_pkg::OP_ADD_RR + 8'(i), 8'h00, da[i], sa[i], (i == 0) ? 4 : 6,
          e[13:6], e[5:0], 6'h3F);
    end
  endtask

  // Add-with-carry chain where each carry feeds the next step
  task automatic test_adc();
    logic [7:0]  da [5];
    logic [7:0]  sa [5];
    logic [13:0] e;
    da = '{8'hFF, 8'h08, 8'h7F, 8'h80, 8'h10};
    sa = '{8'h01, 8'h07, 8'h00, 8'h80, 8'h03};
    for (int i = 0; i < 5; i++) begin
      e = add_exp(da[i], sa[i], fl[alu_pkg::FLAG_C]);
      run(alu_pkg::OP_ADC_RR + 8'(i), 8'h00, da[i], sa[i], (i == 0) ? 4 : 6,
          e[13:6], e[5:0], 6'h3F);
    end
  endtask

  // Byte conjunction after carry and half-carry are set, so keeping shows
  task automatic test_and();
    logic [7:0] da [5];
    logic [7:0] sa [5];
    logic [7:0] r;
    da = '{8'h12, 8'hF0, 8'h21, 8'hFF, 8'h55};
    sa = '{8'h03, 8'h8F, 8'h0A, 8'hFF, 8'hAA};
    run(alu_pkg::OP_ADD_RR, 8'h00, 8'hFF, 8'h01, 4, 8'h00, 6'h31, 6'h3F);
    for (int i = 0; i < 5; i++) begin
      r = da[i] & sa[i];
      run(alu_pkg::OP_AND_RR + 8'(i), 8'h00, da[i], sa[i], (i == 0) ? 4 : 6, r,
          {fl[5], r == 8'h00, r[7], 1'b0, fl[1:0]}, 6'h3F);
    end
  endtask

  // Bit conjunction, both selector forms, every bit index
  task automatic test_band();
    logic [7:0] r;
    logic [7:0] s;
    logic       bv;
    for (int sel = 0; sel < 2; sel++) begin
      for (int b = 0; b < 8; b++) begin
        // Odd indices use a source with bit 0 low, so the indexed form can clear
        s = (b % 2 == 0) ? 8'h3D : 8'h3C;
        r = 8'hA5;
        if (sel == 0) begin
          r[0] = r[0] & s[b];
          bv = r[0];
        end else begin
          r[b] = r[b] & s[0];
          bv = r[b];
        end
        run(alu_pkg::OP_BITAND, {4'h9, 3'(b), 1'(sel)}, 8'hA5, s, 6, r,
            {fl[5], ~bv, 4'h0}, 6'h38);
        chk("waddr", {4'h0, dst_waddr}, 8'h09);
      end
    end
  endtask

  // Start while busy is ignored; unknown opcode commits nothing
  task automatic test_refuse();
    logic [13:0] e;
    int          q;
    e = add_exp(8'h01, 8'h02, 1'b0);
    // Start stays high across the first busy edge, with a new opcode there
    opcode = alu_pkg::OP_ADD_GG;
    byte2  = 8'h00;
    dst_in = 8'h01;
    src_in = 8'h02;
    start  = 1'b1;
    @(posedge clk);
    #1;
    opcode = alu_pkg::OP_AND_RR;
    dst_in = 8'h00;
    @(posedge clk);
    #1;
    start = 1'b0;
    wait_done(2, 6, e[13:6], e[5:0], 6'h3F);
    issue(8'hFF, 8'h00, 8'h44, 8'h44);
    chk("illegal", {7'h00, illegal}, 8'h01);
    @(posedge clk);
    #1;
    chk("illegal pulse", {7'h00, illegal}, 8'h00);
    q = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) begin
        q++;
      end
    end
    chk("stray done", q[7:0], 8'h00);
    chk("result held", result, e[13:6]);
    chk("flags held", {2'b00, flags}, {2'b00, fl});
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    test_add();
    test_adc();
    test_and();
    test_band();
    test_refuse();
    report_and_stop();
  end
endmodule
`default_nettype wire
